// [hw/tsg_events.sv]
// Status flags and software event generation of an advanced 16-bit timer.
// How it works
// - Channel 1 overcapture sets on capture while its flag set; write zero clears.
// - Overcapture flags for channels 4,3,2 sit at bits 12,11,10.
// - Break flag sets on active break; clear works only once break released.
// - Trigger flag sets on trigger edge when slave mode neither off nor gated, or counter start/stop in gated mode.
// - Control-update flag sets when control-update event loads channel controls.
// - Output channel flag sets when counter equals compare value.
// - Compare above reload sets flag at overflow, or underflow when down.
// - Input channel flag sets on capture; cleared by zero write or capture read.
// - Capture/compare flags for channels 4,3,2 sit at bits 4,3,2.
// - Update flag sets on over/underflow when repetition zero and updates enabled.
// - Update-generation sets update flag when source and disable controls zero.
// - Trigger reinitialisation sets update flag when both controls are zero.
// - Update flag stays set until software writes zero.
// - Break-generation clears main output enable and sets break flag.
// - Trigger-generation sets trigger flag.
// - Control-update generation loads channel controls when preload option set.
// - Channel generation on an output channel sets its flag.
// - Channel generation on input captures counter, sets flag, and overcapture if flag already set.
// - Update-generation reinitialises counter, updates unless disabled, clears prescaler count.
// - Reinit clears counter when up or centred, loads reload value when down.
// - Generation bits are write-only, self-clearing; zero writes do nothing.
// - A flag raises its interrupt only when its enable bit is set.
//
// Added by the designer: the strobed register port.
module tsg_events (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [7:0] addr,
  input wire logic [15:0] wdata,
  input wire logic wr_en,
  input wire logic rd_en,
  output logic [15:0] rdata,
  input wire logic break_in,
  input wire logic trigger_input_edge,
  input wire logic counter_run_change,
  input wire logic trigger_reinit,
  input wire logic control_update_evt,
  input wire logic [15:0] counter_value,
  input wire logic [15:0] auto_reload_value,
  input wire logic counter_overflow,
  input wire logic counter_underflow,
  input wire logic repetition_zero,
  input wire logic [3:0] channel_is_input,
  input wire logic [63:0] ch_capture_compare_value,
  input wire logic [3:0] capture_edge,
  input wire logic [3:0] capture_read,
  output logic main_output_enable_clr,
  output logic control_load,
  output logic counter_reinit,
  output logic [15:0] counter_reinit_value,
  output logic prescaler_clear,
  output logic register_update,
  output logic [3:0] capture_strobe,
  output logic [15:0] capture_value,
  output logic irq
);
  logic [15:0] enables;
  logic [15:0] ctrl;
  logic [15:0] flags;
  logic break_s;
  logic wr_flags;
  logic wr_evgen;
  logic [7:0] gen;
  logic [3:0] cc_set;
  logic [3:0] of_set;
  logic [3:0] cc_clr;
  logic upd_set;
  logic trg_set;
  logic brk_set;
  logic com_set;
  logic down;
  logic gated;

  ////////////////////////////////////////////////////////////////////////////
  // Register port.

  tsg_sync #(.W(1)) u_brk_sync (
    .clk_sys(clk_sys),
    .srst(srst),
    .async_in(break_in),
    .sync_out(break_s)
  );

  assign wr_flags = wr_en && (addr == tsg_pkg::OFS_FLAGS);
  assign wr_evgen = wr_en && (addr == tsg_pkg::OFS_EVGEN);
  // Generation bits exist only during the write cycle, so they never read back.
  assign gen = wr_evgen ? wdata[7:0] : 8'h00;
  assign down = ctrl[tsg_pkg::C_DIR] &&
    (ctrl[tsg_pkg::C_CMS0 +: 2] == 2'h0);
  assign gated = ctrl[tsg_pkg::C_SMS0 +: 3] == tsg_pkg::SMS_GATED;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      enables <= tsg_pkg::ENABLES_RST;
      ctrl <= tsg_pkg::CTRL_RST;
    end
    else if (wr_en && addr == tsg_pkg::OFS_ENABLES)
      enables <= {1'b0, wdata[14:0]};
    else if (wr_en && addr == tsg_pkg::OFS_CTRL)
      ctrl <= {5'h00, wdata[10:0]};
  end

  always_ff @(posedge clk_sys)
  begin
    if (srst)
      rdata <= 16'h0000;
    else if (rd_en)
    begin
      case (addr)
        tsg_pkg::OFS_ENABLES: rdata <= enables;
        tsg_pkg::OFS_FLAGS: rdata <= flags;
        tsg_pkg::OFS_CTRL: rdata <= ctrl;
        default: rdata <= 16'h0000;
      endcase
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Event sources.

  assign brk_set = break_s || gen[tsg_pkg::B_BRK];
  assign trg_set = gen[tsg_pkg::B_TRG] ||
    ((ctrl[tsg_pkg::C_SMS0 +: 3] != tsg_pkg::SMS_OFF) &&
     (gated ? counter_run_change : trigger_input_edge));
  assign control_load = gen[tsg_pkg::B_COM] &&
    ctrl[tsg_pkg::C_CONTROL_PRELOAD_OPTION];
  assign com_set = control_update_evt || control_load;
  assign counter_reinit = gen[tsg_pkg::B_UPD];
  assign prescaler_clear = gen[tsg_pkg::B_UPD];
  assign counter_reinit_value = down ? auto_reload_value : 16'h0000;
  assign register_update = !ctrl[tsg_pkg::C_UPDATE_DISABLE] &&
    ((repetition_zero && (counter_overflow || counter_underflow)) ||
     gen[tsg_pkg::B_UPD] || trigger_reinit);
  assign upd_set = !ctrl[tsg_pkg::C_UPDATE_DISABLE] &&
    ((repetition_zero && (counter_overflow || counter_underflow)) ||
     (!ctrl[tsg_pkg::C_URS] &&
      (gen[tsg_pkg::B_UPD] || trigger_reinit)));
  assign main_output_enable_clr = gen[tsg_pkg::B_BRK];

  genvar ch;
  generate
    for (ch = 0; ch < tsg_pkg::NCH; ch = ch + 1)
    begin : g_ch
      logic [15:0] ccv;
      logic sw_gen;
      logic match;
      assign ccv = ch_capture_compare_value[16*ch +: 16];
      assign sw_gen = gen[tsg_pkg::B_CC1 + ch];
      assign match = (ccv > auto_reload_value) ?
        (down ? counter_underflow : counter_overflow) :
        (counter_value == ccv);
      // Capture by edge or by generation bit when the channel is input.
      assign capture_strobe[ch] = channel_is_input[ch] &&
        (capture_edge[ch] || sw_gen);
      assign cc_set[ch] = capture_strobe[ch] ||
        (!channel_is_input[ch] && (match || sw_gen));
      assign of_set[ch] = capture_strobe[ch] &&
        flags[tsg_pkg::B_CC1 + ch];
      assign cc_clr[ch] = (wr_flags && !wdata[tsg_pkg::B_CC1 + ch]) ||
        (capture_read[ch] && channel_is_input[ch]);
      tsg_flag u_cc (
        .clk_sys(clk_sys),
        .srst(srst),
        .set_evt(cc_set[ch]),
        .clr_req(cc_clr[ch]),
        .clr_block(1'b0),
        .flag(flags[tsg_pkg::B_CC1 + ch])
      );
      tsg_flag u_of (
        .clk_sys(clk_sys),
        .srst(srst),
        .set_evt(of_set[ch]),
        .clr_req(wr_flags && !wdata[tsg_pkg::B_OF1 + ch]),
        .clr_block(1'b0),
        .flag(flags[tsg_pkg::B_OF1 + ch])
      );
    end
  endgenerate

  // The counter value captured is the one seen in the capture cycle.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      capture_value <= 16'h0000;
    else if (|capture_strobe)
      capture_value <= counter_value;
  end

  ////////////////////////////////////////////////////////////////////////////
  // Remaining flags.

  tsg_flag u_upd (
    .clk_sys(clk_sys),
    .srst(srst),
    .set_evt(upd_set),
    .clr_req(wr_flags && !wdata[tsg_pkg::B_UPD]),
    .clr_block(1'b0),
    .flag(flags[tsg_pkg::B_UPD])
  );
  tsg_flag u_com (
    .clk_sys(clk_sys),
    .srst(srst),
    .set_evt(com_set),
    .clr_req(wr_flags && !wdata[tsg_pkg::B_COM]),
    .clr_block(1'b0),
    .flag(flags[tsg_pkg::B_COM])
  );
  tsg_flag u_trg (
    .clk_sys(clk_sys),
    .srst(srst),
    .set_evt(trg_set),
    .clr_req(wr_flags && !wdata[tsg_pkg::B_TRG]),
    .clr_block(1'b0),
    .flag(flags[tsg_pkg::B_TRG])
  );
  tsg_flag u_brk (
    .clk_sys(clk_sys),
    .srst(srst),
    .set_evt(brk_set),
    .clr_req(wr_flags && !wdata[tsg_pkg::B_BRK]),
    .clr_block(break_s),
    .flag(flags[tsg_pkg::B_BRK])
  );
  assign flags[8] = 1'b0;
  assign flags[15:13] = 3'h0;

  // Enables in the low byte gate the flags of the same position.
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      irq <= 1'b0;
    else
      irq <= |(flags[7:0] & enables[7:0]);
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks.

  property p_ovc;
    @(posedge clk_sys) disable iff (srst)
    (capture_strobe[0] && flags[tsg_pkg::B_CC1]) |=> flags[tsg_pkg::B_OF1];
  endproperty
  a_ovc: assert property (p_ovc) else $error("overcapture missed");

  property p_brkhold;
    @(posedge clk_sys) disable iff (srst)
    break_s |=> flags[tsg_pkg::B_BRK];
  endproperty
  a_brkhold: assert property (p_brkhold) else $error("break flag lost");

  property p_trggen;
    @(posedge clk_sys) disable iff (srst)
    (wr_evgen && wdata[tsg_pkg::B_TRG]) |=> flags[tsg_pkg::B_TRG];
  endproperty
  a_trggen: assert property (p_trggen) else $error("trigger gen");

  property p_updgen;
    @(posedge clk_sys) disable iff (srst)
    (wr_evgen && wdata[tsg_pkg::B_UPD] && !ctrl[tsg_pkg::C_UPDATE_DISABLE] &&
     !ctrl[tsg_pkg::C_URS]) |=> flags[tsg_pkg::B_UPD];
  endproperty
  a_updgen: assert property (p_updgen) else $error("update gen");

  property p_update_disable;
    @(posedge clk_sys) disable iff (srst)
    (ctrl[tsg_pkg::C_UPDATE_DISABLE] && !flags[0] && !wr_en) |=> !flags[0];
  endproperty
  a_update_disable: assert property (p_update_disable) else $error("update while disabled");

  property p_w1;
    @(posedge clk_sys) disable iff (srst)
    (wr_flags && flags[tsg_pkg::B_UPD] && wdata[tsg_pkg::B_UPD]) |=>
      flags[tsg_pkg::B_UPD];
  endproperty
  a_w1: assert property (p_w1) else $error("write one cleared flag");

  property p_reinit;
    @(posedge clk_sys) disable iff (srst)
    (counter_reinit && (!ctrl[tsg_pkg::C_DIR] ||
     (ctrl[tsg_pkg::C_CMS0 +: 2] != 2'h0))) |->
      (counter_reinit_value == 16'h0000);
  endproperty
  a_reinit: assert property (p_reinit) else $error("reinit value");

  property p_gen0;
    @(posedge clk_sys) disable iff (srst)
    !wr_evgen |-> !counter_reinit && !main_output_enable_clr;
  endproperty
  a_gen0: assert property (p_gen0) else $error("spurious generation");

  property p_irq;
    @(posedge clk_sys) disable iff (srst)
    ((flags[7:0] & enables[7:0]) == 8'h00) |=> !irq;
  endproperty
  a_irq: assert property (p_irq) else $error("irq without enable");
endmodule // tsg_events

// [hw/tsg_flag.sv]
// One sticky status flag: hardware set wins over a software write of zero.
module tsg_flag (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic set_evt,
  input wire logic clr_req,
  input wire logic clr_block,
  output logic flag
);
  always_ff @(posedge clk_sys)
  begin
    if (srst)
      flag <= 1'b0;
    else if (set_evt)
      flag <= 1'b1;
    else if (clr_req && !clr_block)
      flag <= 1'b0;
  end
endmodule // tsg_flag

// [hw/tsg_pkg.sv]
// Package holding offsets, field positions and reset values of the event block.
package tsg_pkg;
  localparam int ADDR_W = 8;
  localparam logic [7:0] OFS_ENABLES = 8'h0C;
  localparam logic [7:0] OFS_FLAGS = 8'h10;
  localparam logic [7:0] OFS_EVGEN = 8'h14;
  localparam logic [7:0] OFS_CTRL = 8'h40;
  localparam logic [15:0] FLAGS_RST = 16'h0000;
  localparam logic [15:0] ENABLES_RST = 16'h0000;
  localparam logic [15:0] CTRL_RST = 16'h0000;
  localparam logic [15:0] FLAGS_MASK = 16'h1EFF;
  localparam logic [15:0] EVGEN_MASK = 16'h00FF;
  localparam int B_UPD = 0;
  localparam int B_CC1 = 1;
  localparam int B_COM = 5;
  localparam int B_TRG = 6;
  localparam int B_BRK = 7;
  localparam int B_OF1 = 9;
  localparam int NCH = 4;
  // Control register fields.
  localparam int C_UPDATE_DISABLE = 0;
  localparam int C_URS = 1;
  localparam int C_CONTROL_PRELOAD_OPTION = 2;
  localparam int C_DIR = 3;
  localparam int C_CMS0 = 4;
  localparam int C_SMS0 = 8;
  localparam logic [2:0] SMS_OFF = 3'h0;
  localparam logic [2:0] SMS_GATED = 3'h5;
endpackage

// [hw/tsg_sync.sv]
// Two-flip-flop synchroniser for asynchronous level inputs.
module tsg_sync #(
  parameter int W = 1
) (
  input wire logic clk_sys,
  input wire logic srst,
  input wire logic [W-1:0] async_in,
  output logic [W-1:0] sync_out
);
  logic [W-1:0] meta;

  always_ff @(posedge clk_sys)
  begin
    if (srst)
    begin
      meta <= '0;
      sync_out <= '0;
    end
    else
    begin
      meta <= async_in;
      sync_out <= meta;
    end
  end
endmodule // tsg_sync

// [verification/tsg_events_bench.sv]
// Self-checking bench for the timer status flags and event generation.
module tsg_events_bench;
  timeunit 1ns;
  timeprecision 1ps;
  localparam logic [7:0] FL = tsg_pkg::OFS_FLAGS;
  localparam logic [7:0] EG = tsg_pkg::OFS_EVGEN;
  localparam logic [7:0] CT = tsg_pkg::OFS_CTRL;
  localparam logic [7:0] EN = tsg_pkg::OFS_ENABLES;
  logic clk_sys = 1'b0;
  logic srst = 1'b1;
  logic [7:0] addr = 8'h00;
  logic [15:0] wdata = 16'h0000;
  logic wr_en = 1'b0;
  logic rd_en = 1'b0;
  logic break_in = 1'b0;
  logic [5:0] evp = 6'h00;
  logic [15:0] cnt = 16'h0000;
  logic [15:0] arr = 16'hFFFF;
  logic rep0 = 1'b1;
  logic [3:0] ch_in = 4'h0;
  logic [3:0] cap_e = 4'h0;
  logic [3:0] cap_r = 4'h0;
  logic [63:0] ccv = {4{16'hFFFF}};
  logic [15:0] rdata, reinit_val, cap_val, seen_rv;
  logic [4:0] pl, seen_pl;
  logic [3:0] cap_st, seen_st;
  logic irq;
  int err_count = 0;
  int comparisons = 0;

  tsg_events uut (
    .clk_sys(clk_sys), .srst(srst), .addr(addr), .wdata(wdata),
    .wr_en(wr_en), .rd_en(rd_en), .rdata(rdata), .break_in(break_in),
    .trigger_input_edge(evp[0]), .counter_run_change(evp[1]),
    .trigger_reinit(evp[2]), .control_update_evt(evp[3]),
    .counter_value(cnt), .auto_reload_value(arr),
    .counter_overflow(evp[4]), .counter_underflow(evp[5]),
    .repetition_zero(rep0), .channel_is_input(ch_in),
    .ch_capture_compare_value(ccv), .capture_edge(cap_e),
    .capture_read(cap_r), .main_output_enable_clr(pl[4]),
    .control_load(pl[3]), .counter_reinit(pl[2]),
    .counter_reinit_value(reinit_val), .prescaler_clear(pl[1]),
    .register_update(pl[0]), .capture_strobe(cap_st),
    .capture_value(cap_val), .irq(irq)
  );

  always #2 clk_sys = ~clk_sys;

  ////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp)
    begin
      err_count++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // Pulses that the write launches are sampled inside the strobe cycle.
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr_en <= 1'b1;
    #1;
    seen_pl = pl;
    seen_st = cap_st;
    seen_rv = reinit_val;
    @(posedge clk_sys);
    wr_en <= 1'b0;
  endtask

  task automatic rdchk(input logic [7:0] a, input logic [15:0] exp);
    @(posedge clk_sys);
    addr <= a;
    rd_en <= 1'b1;
    @(posedge clk_sys);
    rd_en <= 1'b0;
    #1;
    chk(rdata, exp);
  endtask

  task automatic fire(input int i);
    @(posedge clk_sys);
    evp[i] <= 1'b1;
    @(posedge clk_sys);
    evp <= 6'h00;
  endtask

  task automatic cpulse(input logic [3:0] e, input logic [3:0] r);
    @(posedge clk_sys);
    cap_e <= e;
    cap_r <= r;
    @(posedge clk_sys);
    cap_e <= 4'h0;
    cap_r <= 4'h0;
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic t_update;
    rdchk(FL, 16'h0000);
    rdchk(8'h20, 16'h0000);
    wr(EG, 16'h0001);
    chk({11'h000, seen_pl}, 16'h0007);
    chk(seen_rv, 16'h0000);
    rdchk(FL, 16'h0001);
    rdchk(EG, 16'h0000);
    wr(FL, tsg_pkg::FLAGS_MASK);
    rdchk(FL, 16'h0001);
    wr(FL, 16'h0000);
    wr(EG, 16'h0000);
    chk({11'h000, seen_pl}, 16'h0000);
    rdchk(FL, 16'h0000);
    wr(CT, 16'h0002 | (16'h0001 << tsg_pkg::C_DIR));
    wr(EG, 16'h0001);
    chk(seen_rv, arr);
    rdchk(FL, 16'h0000);
    wr(CT, 16'h0018);
    wr(EG, 16'h0001);
    chk(seen_rv, 16'h0000);
    rdchk(FL, 16'h0001);
    wr(FL, 16'h0000);
  endtask

  task automatic t_overflow;
    wr(CT, 16'h0000);
    fire(4);
    rdchk(FL, 16'h0001);
    wr(FL, 16'h0000);
    rep0 <= 1'b0;
    fire(5);
    rdchk(FL, 16'h0000);
    rep0 <= 1'b1;
    wr(CT, 16'h0001);
    fire(4);
    rdchk(FL, 16'h0000);
    wr(CT, 16'h0000);
    fire(2);
    rdchk(FL, 16'h0001);
    wr(FL, 16'h0000);
    wr(CT, 16'h0002);
    fire(2);
    rdchk(FL, 16'h0000);
  endtask

  task automatic t_break;
    break_in <= 1'b1;
    repeat (4) @(posedge clk_sys);
    rdchk(FL, 16'h0080);
    wr(FL, 16'h0000);
    rdchk(FL, 16'h0080);
    break_in <= 1'b0;
    repeat (4) @(posedge clk_sys);
    wr(FL, 16'h0000);
    rdchk(FL, 16'h0000);
    wr(EG, 16'h0080);
    chk({15'h0000, seen_pl[4]}, 16'h0001);
    rdchk(FL, 16'h0080);
    wr(FL, 16'h0000);
  endtask

  task automatic t_trigger;
    fire(0);
    rdchk(FL, 16'h0000);
    wr(CT, 16'h0600);
    fire(0);
    rdchk(FL, 16'h0040);
    wr(FL, 16'h0000);
    wr(CT, 16'h0500);
    fire(0);
    rdchk(FL, 16'h0000);
    fire(1);
    rdchk(FL, 16'h0040);
    wr(FL, 16'h0000);
    wr(EG, 16'h0040);
    rdchk(FL, 16'h0040);
    wr(CT, 16'h0004);
    wr(EG, 16'h0020);
    chk({15'h0000, seen_pl[3]}, 16'h0001);
    wr(CT, 16'h0000);
    wr(EG, 16'h0020);
    chk({15'h0000, seen_pl[3]}, 16'h0000);
    wr(FL, 16'h0000);
    fire(3);
    rdchk(FL, 16'h0020);
    wr(FL, 16'h0000);
  endtask

  // Every channel in turn, so a slip in one lane's bit position shows.
  task automatic t_channels;
    logic [15:0] f;
    for (int c = 0; c < 4; c++)
    begin
      f = 16'h0002 << c;
      ch_in <= 4'hF;
      cpulse(4'h1 << c, 4'h0);
      rdchk(FL, f);
      cpulse(4'h1 << c, 4'h0);
      rdchk(FL, f | (f << 8));
      cpulse(4'h0, 4'h1 << c);
      rdchk(FL, f << 8);
      wr(FL, 16'h0000);
      cnt <= 16'h1230 + 16'(c);
      wr(EG, f);
      #1;
      chk({12'h000, seen_st}, 16'h0001 << c);
      chk(cap_val, 16'h1230 + 16'(c));
      wr(EG, f);
      rdchk(FL, f | (f << 8));
      wr(FL, 16'h0000);
      ch_in <= 4'h0;
      cnt <= 16'h0000;
      wr(EG, f);
      chk({12'h000, seen_st}, 16'h0000);
      rdchk(FL, f);
      wr(FL, 16'h0000);
    end
    ccv[31:16] <= 16'h0123;
    @(posedge clk_sys);
    cnt <= 16'h0123;
    @(posedge clk_sys);
    cnt <= 16'h0000;
    rdchk(FL, 16'h0004);
    wr(FL, 16'h0000);
    arr <= 16'h0100;
    fire(4);
    rdchk(FL, 16'h001F);
    wr(FL, 16'h0000);
    wr(CT, 16'h0008);
    fire(5);
    rdchk(FL, 16'h001F);
    arr <= 16'hFFFF;
    ccv <= {4{16'hFFFF}};
    wr(CT, 16'h0000);
    wr(FL, 16'h0000);
  endtask

  task automatic t_irq;
    wr(EG, 16'h0001);
    wr(EN, 16'h0040);
    rdchk(FL, 16'h0001);
    chk({15'h0000, irq}, 16'h0000);
    wr(EN, 16'h0001);
    rdchk(FL, 16'h0001);
    chk({15'h0000, irq}, 16'h0001);
    wr(FL, 16'h0000);
    rdchk(FL, 16'h0000);
    chk({15'h0000, irq}, 16'h0000);
  endtask

  ////////////////////////////////////////////////////////////////////////
  task automatic wrap_up;
    if (err_count == 0 && comparisons > 0)
      $display("NO MISMATCHES");
    else
      $display("MISMATCHES SEEN");
    $finish;
  endtask

  initial
  begin
    repeat (12) @(posedge clk_sys);
    srst <= 1'b0;
    t_update();
    t_overflow();
    t_break();
    t_trigger();
    t_channels();
    t_irq();
    wrap_up();
  end

  // The scenarios need well under two thousand cycles.
  initial
  begin
    repeat (20000) @(posedge clk_sys);
    err_count++;
    wrap_up();
  end
endmodule // tsg_events_bench
